/* File: verilog/xbus_pkg.sv */
// Types for the external bus pin sequencer.
// Assumes a single synchronous clock domain.
package xbus_pkg;
  typedef enum logic [1:0] {
    XBUS_SP_NORMAL,
    XBUS_SP_MUXIO,
    XBUS_SP_DRAM
  } xbus_space_t;
  typedef enum logic [1:0] {
    XBUS_SZ_BYTE8,
    XBUS_SZ_UPPER,
    XBUS_SZ_LOWER,
    XBUS_SZ_WORD
  } xbus_size_t;
  typedef enum logic [2:0] {
    XBUS_IDLE,
    XBUS_ADDR,
    XBUS_ROW,
    XBUS_COL,
    XBUS_DATA
  } xbus_state_t;
endpackage

/* File: verilog/xbus_regs.svh */
// Timing counts and reset levels of the external bus pins.
// Included by design files only.
`ifndef XBUS_REGS_SVH
`define XBUS_REGS_SVH
`define XBUS_ADDR_CYC 2'h1
`define XBUS_DATA_CYC 2'h2
`define XBUS_PIN_IDLE 1'h1
`endif

/* File: verilog/xbus_lane_drv.sv */
// Data lane driver for one byte lane: address phase then data phase.
// Assumes enables are decoded by the sequencer.
`timescale 1ns/10ps
module xbus_lane_drv (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       drive_addr,
  input  wire logic       drive_data,
  input  wire logic [7:0] addr_byte,
  input  wire logic [7:0] data_byte,
  output logic      [7:0] lane_out,
  output logic            lane_oe
);
  // Registered so the pin follows one flip-flop
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lane_out <= 8'h00;
      lane_oe  <= 1'b0;
    end else if (clk_en) begin
      lane_oe  <= drive_addr | drive_data;
      lane_out <= drive_addr ? addr_byte : (drive_data ? data_byte : 8'h00);
    end
  end
endmodule

/* File: verilog/xbus_pins.sv */
// External bus pin sequencer for multiplexed I/O and DRAM spaces.
// Assumes a request pulse is given only while busy is low.
`timescale 1ns/10ps
`include "xbus_regs.svh"
// Contract
// - Pulse address hold high in each muxed I/O address phase.
// - Muxed: upper lane off in 8-bit; else address, then data if sized and writing.
// - Row strobe goes low on every DRAM access, any width or size.
// - Upper column strobe for upper/word; lower for 8-bit, lower, word.
// - Row strobe also held low in row-held mode and during refresh.
// - Both column strobes held low during refresh.
module xbus_pins
  import xbus_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  arst_n,
  input  wire logic                  clk_en,
  input  wire logic                  req,
  input  wire xbus_pkg::xbus_space_t space,
  input  wire xbus_pkg::xbus_size_t  size,
  input  wire logic                  write,
  input  wire logic [15:0]           addr_lo,
  input  wire logic [15:0]           wdata,
  input  wire logic                  ras_down_mode,
  input  wire logic                  refresh,
  output logic                       busy,
  output logic                       io_space_select_n,
  output logic                       row_strobe_n,
  output logic                       upper_column_strobe_n,
  output logic                       lower_column_strobe_n,
  output logic                       dram_write_direction,
  output logic                       address_hold_strobe,
  output logic [7:0]                 data_hi_out,
  output logic                       data_hi_oe,
  output logic [7:0]                 data_lo_out,
  output logic                       data_lo_oe
);
  import xbus_pkg::*;

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  xbus_state_t state;
  xbus_space_t cur_space;
  xbus_size_t  cur_size;
  logic        cur_write;
  logic [15:0] cur_addr;
  logic [15:0] cur_data;
  logic [1:0]  cnt;

  function automatic logic upper_used(input xbus_size_t s);
    upper_used = (s == XBUS_SZ_UPPER) || (s == XBUS_SZ_WORD);
  endfunction
  function automatic logic lower_used(input xbus_size_t s);
    lower_used = (s != XBUS_SZ_UPPER);
  endfunction

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= XBUS_IDLE;
      cnt       <= 2'h0;
      cur_space <= XBUS_SP_NORMAL;
      cur_size  <= XBUS_SZ_BYTE8;
      cur_write <= 1'b0;
      cur_addr  <= 16'h0000;
      cur_data  <= 16'h0000;
    end else if (clk_en) begin
      unique case (state)
        XBUS_IDLE: begin
          if (req) begin
            cur_space <= space;
            cur_size  <= size;
            cur_write <= write;
            cur_addr  <= addr_lo;
            cur_data  <= wdata;
            if (space == XBUS_SP_MUXIO) begin
              state <= XBUS_ADDR;
              cnt   <= `XBUS_ADDR_CYC;
            end else if (space == XBUS_SP_DRAM) begin
              state <= XBUS_ROW;
              cnt   <= `XBUS_ADDR_CYC;
            end else begin
              state <= XBUS_DATA;
              cnt   <= `XBUS_DATA_CYC;
            end
          end
        end
        XBUS_ADDR: begin
          if (cnt == 2'h1) begin
            state <= XBUS_DATA;
            cnt   <= `XBUS_DATA_CYC;
          end else begin
            cnt <= cnt - 2'h1;
          end
        end
        XBUS_ROW: begin
          if (cnt == 2'h1) begin
            state <= XBUS_COL;
            cnt   <= `XBUS_DATA_CYC;
          end else begin
            cnt <= cnt - 2'h1;
          end
        end
        XBUS_COL, XBUS_DATA: begin
          if (cnt == 2'h1) begin
            state <= XBUS_IDLE;
            cnt   <= 2'h0;
          end else begin
            cnt <= cnt - 2'h1;
          end
        end
        // Unused codes fall back to idle rather than lock the pins
        default: begin
          state <= XBUS_IDLE;
          cnt   <= 2'h0;
        end
      endcase
    end
  end

  // ****************************************
  // Next pin levels
  // ****************************************
  xbus_state_t next_state;
  logic next_hold;
  logic next_ras_n;
  logic next_upcol_n;
  logic next_locol_n;
  logic in_dram;
  logic in_muxio;
  always_comb begin
    next_state = state;
    if (clk_en) begin
      unique case (state)
        XBUS_IDLE:
          next_state = !req ? XBUS_IDLE :
                       (space == XBUS_SP_MUXIO) ? XBUS_ADDR :
                       (space == XBUS_SP_DRAM) ? XBUS_ROW : XBUS_DATA;
        XBUS_ADDR: next_state = (cnt == 2'h1) ? XBUS_DATA : XBUS_ADDR;
        XBUS_ROW:  next_state = (cnt == 2'h1) ? XBUS_COL : XBUS_ROW;
        XBUS_COL, XBUS_DATA:
          next_state = (cnt == 2'h1) ? XBUS_IDLE : state;
        default: next_state = XBUS_IDLE;
      endcase
    end
    in_dram  = (next_state == XBUS_ROW) || (next_state == XBUS_COL);
    in_muxio = (next_state == XBUS_ADDR) ||
               ((next_state == XBUS_DATA) &&
                (((state == XBUS_IDLE) ? space : cur_space) == XBUS_SP_MUXIO));
    next_hold    = (next_state == XBUS_ADDR);
    next_ras_n   = !(in_dram || ras_down_mode ||
                     refresh);
    next_upcol_n = !((next_state == XBUS_COL) &&
                     upper_used(cur_size) ||
                     refresh);
    next_locol_n = !((next_state == XBUS_COL) &&
                     lower_used(cur_size) ||
                     refresh);
  end

  // ****************************************
  // Strobe outputs
  // ****************************************
  // Column decode uses the captured size, valid since it is latched on the request in IDLE
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      address_hold_strobe   <= 1'b0;
      row_strobe_n          <= `XBUS_PIN_IDLE;
      upper_column_strobe_n <= `XBUS_PIN_IDLE;
      lower_column_strobe_n <= `XBUS_PIN_IDLE;
      dram_write_direction  <= `XBUS_PIN_IDLE;
      io_space_select_n     <= `XBUS_PIN_IDLE;
      busy                  <= 1'b0;
    end else if (clk_en) begin
      address_hold_strobe   <= next_hold;
      row_strobe_n          <= next_ras_n;
      upper_column_strobe_n <= next_upcol_n;
      lower_column_strobe_n <= next_locol_n;
      // Write level only while a DRAM access runs
      dram_write_direction  <= !(in_dram &&
        ((state == XBUS_IDLE) ? write : cur_write));
      io_space_select_n     <= !in_muxio;
      busy                  <= (next_state != XBUS_IDLE);
    end
  end

  // ****************************************
  // Data lanes
  // ****************************************
  logic hi_addr;
  logic hi_data;
  logic lo_addr;
  logic lo_data;
  xbus_size_t lane_size;
  logic       lane_write;
  always_comb begin
    // Normal space enters data from idle, before the request is captured
    lane_size  = (state == XBUS_IDLE) ? size : cur_size;
    lane_write = (state == XBUS_IDLE) ? write : cur_write;
    // 8-bit space keeps the upper lane floating
    hi_addr = (next_state == XBUS_ADDR) &&
              (lane_size != XBUS_SZ_BYTE8);
    lo_addr = (next_state == XBUS_ADDR);
    hi_data = (next_state == XBUS_DATA || next_state == XBUS_COL) &&
              upper_used(lane_size) && lane_write;
    lo_data = (next_state == XBUS_DATA || next_state == XBUS_COL) &&
              lower_used(lane_size) && lane_write;
  end

  xbus_lane_drv u_hi (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .clk_en     (clk_en),
    .drive_addr (hi_addr),
    .drive_data (hi_data),
    .addr_byte  ((state == XBUS_IDLE) ? addr_lo[15:8] : cur_addr[15:8]),
    .data_byte  ((state == XBUS_IDLE) ? wdata[15:8] : cur_data[15:8]),
    .lane_out   (data_hi_out),
    .lane_oe    (data_hi_oe)
  );
  xbus_lane_drv u_lo (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .clk_en     (clk_en),
    .drive_addr (lo_addr),
    .drive_data (lo_data),
    .addr_byte  ((state == XBUS_IDLE) ? addr_lo[7:0] : cur_addr[7:0]),
    .data_byte  ((state == XBUS_IDLE) ? wdata[7:0] : cur_data[7:0]),
    .lane_out   (data_lo_out),
    .lane_oe    (data_lo_oe)
  );

  // ****************************************
  // Checks
  // ****************************************
  sequence s_muxio_start;
    clk_en && state == XBUS_IDLE && req && space == XBUS_SP_MUXIO;
  endsequence
  a_hold_pulse: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_muxio_start ##1 1'b1 |-> address_hold_strobe)
    else $error("address hold missing");
  a_hold_only_muxio: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    address_hold_strobe |->
      !io_space_select_n && busy && dram_write_direction)
    else $error("address hold outside muxed access");
  a_ras_dram: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && state == XBUS_IDLE && req && space == XBUS_SP_DRAM
    |=> !row_strobe_n)
    else $error("row strobe not asserted");
  a_ras_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && (ras_down_mode || refresh) |=> !row_strobe_n)
    else $error("row strobe not held");
  a_cas_refresh: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && refresh |=>
      !upper_column_strobe_n && !lower_column_strobe_n)
    else $error("column strobes not in refresh");
  a_upcol_size: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !upper_column_strobe_n && !$past(refresh) |-> upper_used(cur_size))
    else $error("upper column strobe misused");
  a_dir_idle: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !dram_write_direction |-> cur_write && busy)
    else $error("write direction low outside dram write");
  a_hi_lane_8bit: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    busy && cur_size == XBUS_SZ_BYTE8 && state != XBUS_IDLE
    |-> !data_hi_oe)
    else $error("upper lane driven in 8-bit space");
endmodule

/* File: sim/xbus_far_side.sv */
// Far-side model: muxed peripheral and DRAM seen from the board lanes.
// Assumes no pull resistors on the data lanes.
`timescale 1ns/10ps
module xbus_far_side (
  input  wire logic        sys_clk,
  input  wire logic        address_hold_strobe,
  input  wire logic [7:0]  data_hi_out,
  input  wire logic        data_hi_oe,
  input  wire logic [7:0]  data_lo_out,
  input  wire logic        data_lo_oe,
  output logic      [15:0] d_wire,
  output logic      [15:0] addr_seen
);
  // No pull on the lanes, so a released lane floats
  assign d_wire = {data_hi_oe ? data_hi_out : 8'hZZ,
                   data_lo_oe ? data_lo_out : 8'hZZ};
  // Peripheral latches the address while the hold strobe is high
  always_ff @(posedge sys_clk) begin
    if (address_hold_strobe) begin
      addr_seen <= d_wire;
    end
  end
endmodule

/* File: sim/ext_bus_mux_io_dram_pins_tb_top.sv */
// Testbench for the external bus pin sequencer.
// Assumes one clock; data lanes resolved by the far-side model.
`timescale 1ns/10ps
module ext_bus_mux_io_dram_pins_tb_top;
  import xbus_pkg::*;
  logic sys_clk, arst_n, clk_en, req, write, ras_down_mode, refresh;
  xbus_space_t space;
  xbus_size_t size;
  logic [15:0] addr_lo, wdata, d_wire, addr_seen;
  logic busy, io_space_select_n, row_strobe_n, upper_column_strobe_n;
  logic lower_column_strobe_n, dram_write_direction, address_hold_strobe;
  logic [7:0] data_hi_out, data_lo_out;
  logic data_hi_oe, data_lo_oe;
  int err_count, checked;
  // ****************************************
  // Clock, reset and instances
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  xbus_pins u_dut (.sys_clk, .arst_n, .clk_en, .req, .space, .size,
    .write, .addr_lo, .wdata, .ras_down_mode, .refresh, .busy,
    .io_space_select_n, .row_strobe_n, .upper_column_strobe_n,
    .lower_column_strobe_n, .dram_write_direction, .address_hold_strobe,
    .data_hi_out, .data_hi_oe, .data_lo_out, .data_lo_oe);
  xbus_far_side u_far (.sys_clk, .address_hold_strobe, .data_hi_out,
    .data_hi_oe, .data_lo_out, .data_lo_oe, .d_wire, .addr_seen);
  // ****************************************
  // Shared tasks
  // ****************************************
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task step;
    @(posedge sys_clk);
    #1;
  endtask
  // Request, then land one ns after the first phase edge
  task go(input xbus_space_t sp, input xbus_size_t sz, input logic wr);
    @(posedge sys_clk);
    req <= 1'b1;
    space <= sp;
    size <= sz;
    write <= wr;
    @(posedge sys_clk);
    req <= 1'b0;
    #1;
  endtask
  function automatic logic [2:0] strb;
    strb = {row_strobe_n, upper_column_strobe_n, lower_column_strobe_n};
  endfunction
  // ****************************************
  // Scenarios
  // ****************************************
  task t_mux;
    logic       hu, lu;
    logic [7:0] ahi, dhi, dlo;
    logic [4:0] ctl;
    for (int i = 0; i < 4; i++) begin
      hu  = (i == 1) || (i == 3);
      lu  = (i != 1);
      ahi = (i == 0) ? 8'hZZ : 8'hA5;
      dhi = hu ? 8'h3C : 8'hZZ;
      dlo = lu ? 8'hC3 : 8'hZZ;
      go(XBUS_SP_MUXIO, xbus_size_t'(i), 1'h1);
      ctl = {address_hold_strobe, io_space_select_n, strb()};
      chk("mux_ctl", ctl, 5'h17);
      chk("mux_alane", d_wire, {ahi, 8'h5A});
      step;
      chk("mux_latch", addr_seen, {ahi, 8'h5A});
      chk("mux_hold_low", address_hold_strobe, 1'h0);
      chk("mux_dlane", d_wire, {dhi, dlo});
      step;
      step;
      chk("mux_end", {busy, io_space_select_n}, 2'h1);
      chk("mux_float", d_wire, 16'hZZZZ);
    end
    $display("test mux done");
  endtask
  task t_dram;
    logic [2:0] col;
    for (int w = 0; w < 2; w++) begin
      for (int i = 0; i < 4; i++) begin
        col = {1'h0, !(i == 1 || i == 3), i == 1};
        go(XBUS_SP_DRAM, xbus_size_t'(i), w[0]);
        chk("dram_row", strb(), 3'h3);
        step;
        chk("dram_col", strb(), col);
        chk("dram_dir", dram_write_direction, !w[0]);
        step;
        step;
        chk("dram_end", {busy, strb()}, 4'h7);
        chk("dram_dir_end", dram_write_direction, 1'h1);
      end
    end
    $display("test dram done");
  endtask
  task t_hold;
    @(posedge sys_clk);
    refresh <= 1'h1;
    step;
    step;
    chk("refresh", strb(), 3'h0);
    @(posedge sys_clk);
    refresh       <= 1'h0;
    ras_down_mode <= 1'h1;
    step;
    chk("ras_down", strb(), 3'h3);
    @(posedge sys_clk);
    ras_down_mode <= 1'h0;
    step;
    chk("hold_off", strb(), 3'h7);
    $display("test hold done");
  endtask
  // Clock enable low mid-access must freeze the strobes and the count
  task t_freeze;
    go(XBUS_SP_DRAM, XBUS_SZ_WORD, 1'h0);
    @(posedge sys_clk);
    clk_en <= 1'h0;
    repeat (3) step;
    chk("frozen", {busy, strb()}, 4'h8);
    @(posedge sys_clk);
    clk_en <= 1'h1;
    step;
    chk("thawed", {busy, strb()}, 4'h8);
    step;
    chk("resumed", {busy, strb()}, 4'h7);
    $display("test freeze done");
  endtask
  // Normal access, with a DRAM request while busy that must be ignored
  task t_normal;
    logic [5:0] pins;
    go(XBUS_SP_NORMAL, XBUS_SZ_WORD, 1'h0);
    pins = {busy, dram_write_direction, strb(), address_hold_strobe};
    chk("norm_pins", pins, 6'h3E);
    chk("norm_lanes", d_wire, 16'hZZZZ);
    @(posedge sys_clk);
    req <= 1'b1;
    space <= XBUS_SP_DRAM;
    @(posedge sys_clk);
    req <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      step;
      chk("refused", {busy, row_strobe_n}, 2'h1);
    end
    $display("test normal done");
  endtask
  // ****************************************
  // Run control
  // ****************************************
  task complete_run;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    complete_run;
  end
  initial begin
    {arst_n, req, write, ras_down_mode, refresh} = 5'h0;
    clk_en = 1'h1;
    space = XBUS_SP_NORMAL;
    size = XBUS_SZ_BYTE8;
    addr_lo = 16'hA55A;
    wdata = 16'h3CC3;
    err_count = 0;
    checked = 0;
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_mux;
    t_dram;
    t_hold;
    t_normal;
    t_freeze;
    complete_run;
  end
endmodule
